// ---- rtl/stfsb_regs.vh ----
// Constants for the self-test fault status bank
// Assumes inclusion by the bank and its flag cell; no process here
`ifndef STFSB_REGS_VH
`define STFSB_REGS_VH

// Register select codes on the read command port
`define STFSB_SEL_OVERVOLT  2'h0
`define STFSB_SEL_PROTECT   2'h1
`define STFSB_SEL_THERMMEM  2'h2

// Reset value of every register
`define STFSB_RESET_VAL     8'h00

// Implemented bits per register
`define STFSB_OV_MASK       8'hbb
`define STFSB_PR_MASK       8'hbb
`define STFSB_TM_MASK       8'h1b

// Field positions, over-voltage register
`define STFSB_OV_INTREG     7
`define STFSB_OV_EXTMON2    5
`define STFSB_OV_EXTMON1    4
`define STFSB_OV_BOOST      3
`define STFSB_OV_BUCKB      1
`define STFSB_OV_BUCKA      0

// Field positions, protection register
`define STFSB_PR_CL_BOOST   7
`define STFSB_PR_CL_BUCKB   5
`define STFSB_PR_CL_BUCKA   4
`define STFSB_PR_OP_BOOST   3
`define STFSB_PR_OP_BUCKB   1
`define STFSB_PR_OP_BUCKA   0

// Field positions, thermal and memory register
`define STFSB_TM_NVM        4
`define STFSB_TM_OT_BOOST   3
`define STFSB_TM_OT_BUCKB   1
`define STFSB_TM_OT_BUCKA   0

`endif

// ---- rtl/stfsb_flag_reg.v ----
// One 8-bit sticky fault register cleared by reads
// Assumes fail inputs synchronous to clk, one read pulse per command
`timescale 1ns/1ps
`default_nettype none
`include "stfsb_regs.vh"

module stfsb_flag_reg #(
	parameter [7:0] MASK = 8'hff
) (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       rstn,
	// Fault conditions and read strobe
	input  wire [7:0] failIn,
	input  wire       rdPulse,
	// Register value
	output wire [7:0] flags
);

	reg [7:0] flags_r;
	genvar i;

	generate
		for (i = 0; i < 8; i = i + 1) begin : g_bit
			if (MASK[i]) begin : g_flag
				always @(posedge ref_clk or negedge rstn) begin
					if (!rstn) begin
						flags_r[i] <= 1'b0;
					end else if (failIn[i]) begin
						flags_r[i] <= 1'b1;
					end else if (rdPulse) begin
						flags_r[i] <= 1'b0;
					end
				end
			end else begin : g_rsvd
				always @(posedge ref_clk or negedge rstn) begin
					if (!rstn) begin
						flags_r[i] <= 1'b0;
					end else begin
						flags_r[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	assign flags = flags_r;

endmodule
`default_nettype wire

// ---- rtl/stfsb_bank.v ----
// Self-test fault status bank: three read-only sticky fault registers
// Assumes a frame decoder giving one-cycle read and write strobes
//
// Summary of operation
// - A fault flag stays set until its register is read.
// - Reading clears flags whose fault is gone; persisting faults stay set.
// - Power-on reset zeroes all flags; reads clear only those whose fault is gone.
// - Registers are read-only, each by its own read command.
// - Flag reads one on fault, zero otherwise.
// - Over-voltage register bits 7,5,4,3,1,0; bits 6,2 zero.
// - Protection register current-limit faults at bits 7,5,4.
// - Protection register output protection faults at bits 3,1,0.
// - Thermal register nvm checksum fault bit 4; bits 7-5 zero.
// - Thermal register over-temperature faults bits 3,1,0; bit 2 zero.
`timescale 1ns/1ps
`default_nettype none
`include "stfsb_regs.vh"

module stfsb_bank (
	// Clock and power-on reset
	input  wire       ref_clk,
	input  wire       rstn,
	// Read and write commands from frame logic
	input  wire       rdStrobe,
	input  wire [1:0] rdSel,
	input  wire       wrStrobe,
	input  wire [1:0] wrSel,
	input  wire [7:0] wrData,
	// Over-voltage self-test faults
	input  wire       st_internal_reg_overvolt_fail,
	input  wire       st_ext_monitor2_overvolt_fail,
	input  wire       st_ext_monitor1_overvolt_fail,
	input  wire       st_boost_overvolt_fail,
	input  wire       st_buck_b_overvolt_fail,
	input  wire       st_buck_a_overvolt_fail,
	// Protection self-test faults
	input  wire       st_boost_current_limit_fail,
	input  wire       st_buck_b_current_limit_fail,
	input  wire       st_buck_a_current_limit_fail,
	input  wire       st_boost_out_protect_fail,
	input  wire       st_buck_b_out_protect_fail,
	input  wire       st_buck_a_out_protect_fail,
	// Thermal and memory self-test faults
	input  wire       st_nvm_checksum_monitor_fail,
	input  wire       st_boost_overtemp_fail,
	input  wire       st_buck_b_overtemp_fail,
	input  wire       st_buck_a_overtemp_fail,
	// Read answer
	output wire [7:0] rdData,
	output wire       rdValid,
	output wire       rdError
);

	// Implemented bits and unmapped select
	localparam [7:0] OV_MASK  = `STFSB_OV_MASK;
	localparam [7:0] PR_MASK  = `STFSB_PR_MASK;
	localparam [7:0] TM_MASK  = `STFSB_TM_MASK;
	localparam [1:0] SEL_NONE = 2'h3;

	// Fault vectors at bit positions
	reg  [7:0] ovFail;
	reg  [7:0] prFail;
	reg  [7:0] tmFail;
	wire [7:0] ovSet;
	wire [7:0] prSet;
	wire [7:0] tmSet;
	// Stored flags and read views
	wire [7:0] ovFlags;
	wire [7:0] prFlags;
	wire [7:0] tmFlags;
	reg  [7:0] ovView;
	reg  [7:0] prView;
	reg  [7:0] tmView;
	// Command decode
	wire       selOv;
	wire       selPr;
	wire       selTm;
	wire       selNone;
	wire       rdOv;
	wire       rdPr;
	wire       rdTm;
	wire       rdUnmapped;
	wire       wrAttempt;
	// Field flags, over-voltage register
	wire       fIntReg;
	wire       fExtMon2;
	wire       fExtMon1;
	wire       fOvBoost;
	wire       fOvBuckB;
	wire       fOvBuckA;
	// Field flags, protection register
	wire       fClBoost;
	wire       fClBuckB;
	wire       fClBuckA;
	wire       fOpBoost;
	wire       fOpBuckB;
	wire       fOpBuckA;
	// Field flags, thermal and memory register
	wire       fNvm;
	wire       fOtBoost;
	wire       fOtBuckB;
	wire       fOtBuckA;
	// Read answer
	reg  [7:0] rdData_r;
	reg  [7:0] rdData_nxt;
	reg        rdValid_r;
	reg        rdError_r;

	// Fault vectors at their bit positions
	always @* begin
		ovFail = 8'h00;
		ovFail[`STFSB_OV_INTREG]  = st_internal_reg_overvolt_fail;
		ovFail[`STFSB_OV_EXTMON2] = st_ext_monitor2_overvolt_fail;
		ovFail[`STFSB_OV_EXTMON1] = st_ext_monitor1_overvolt_fail;
		ovFail[`STFSB_OV_BOOST]   = st_boost_overvolt_fail;
		ovFail[`STFSB_OV_BUCKB]   = st_buck_b_overvolt_fail;
		ovFail[`STFSB_OV_BUCKA]   = st_buck_a_overvolt_fail;
	end

	always @* begin
		prFail = 8'h00;
		prFail[`STFSB_PR_CL_BOOST] = st_boost_current_limit_fail;
		prFail[`STFSB_PR_CL_BUCKB] = st_buck_b_current_limit_fail;
		prFail[`STFSB_PR_CL_BUCKA] = st_buck_a_current_limit_fail;
		prFail[`STFSB_PR_OP_BOOST] = st_boost_out_protect_fail;
		prFail[`STFSB_PR_OP_BUCKB] = st_buck_b_out_protect_fail;
		prFail[`STFSB_PR_OP_BUCKA] = st_buck_a_out_protect_fail;
	end

	always @* begin
		tmFail = 8'h00;
		tmFail[`STFSB_TM_NVM]      = st_nvm_checksum_monitor_fail;
		tmFail[`STFSB_TM_OT_BOOST] = st_boost_overtemp_fail;
		tmFail[`STFSB_TM_OT_BUCKB] = st_buck_b_overtemp_fail;
		tmFail[`STFSB_TM_OT_BUCKA] = st_buck_a_overtemp_fail;
	end

	// Reserved positions can never set
	assign ovSet = ovFail & OV_MASK;
	assign prSet = prFail & PR_MASK;
	assign tmSet = tmFail & TM_MASK;

	// Register select decode
	assign selOv   = (rdSel == `STFSB_SEL_OVERVOLT);
	assign selPr   = (rdSel == `STFSB_SEL_PROTECT);
	assign selTm   = (rdSel == `STFSB_SEL_THERMMEM);
	assign selNone = (rdSel == SEL_NONE);

	// Each register cleared only by its own read command
	assign rdOv = rdStrobe && selOv;
	assign rdPr = rdStrobe && selPr;
	assign rdTm = rdStrobe && selTm;

	// Refused commands
	assign rdUnmapped = rdStrobe && selNone;
	assign wrAttempt  = wrStrobe;

	// Sticky flag registers
	stfsb_flag_reg #(
		.MASK (`STFSB_OV_MASK)
	) u_ov (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.failIn  (ovSet),
		.rdPulse (rdOv),
		.flags   (ovFlags)
	);

	stfsb_flag_reg #(
		.MASK (`STFSB_PR_MASK)
	) u_pr (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.failIn  (prSet),
		.rdPulse (rdPr),
		.flags   (prFlags)
	);

	stfsb_flag_reg #(
		.MASK (`STFSB_TM_MASK)
	) u_tm (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.failIn  (tmSet),
		.rdPulse (rdTm),
		.flags   (tmFlags)
	);

	// Field flags, over-voltage register
	assign fIntReg  = ovFlags[`STFSB_OV_INTREG];
	assign fExtMon2 = ovFlags[`STFSB_OV_EXTMON2];
	assign fExtMon1 = ovFlags[`STFSB_OV_EXTMON1];
	assign fOvBoost = ovFlags[`STFSB_OV_BOOST];
	assign fOvBuckB = ovFlags[`STFSB_OV_BUCKB];
	assign fOvBuckA = ovFlags[`STFSB_OV_BUCKA];

	// Field flags, protection register
	assign fClBoost = prFlags[`STFSB_PR_CL_BOOST];
	assign fClBuckB = prFlags[`STFSB_PR_CL_BUCKB];
	assign fClBuckA = prFlags[`STFSB_PR_CL_BUCKA];
	assign fOpBoost = prFlags[`STFSB_PR_OP_BOOST];
	assign fOpBuckB = prFlags[`STFSB_PR_OP_BUCKB];
	assign fOpBuckA = prFlags[`STFSB_PR_OP_BUCKA];

	// Field flags, thermal and memory register
	assign fNvm     = tmFlags[`STFSB_TM_NVM];
	assign fOtBoost = tmFlags[`STFSB_TM_OT_BOOST];
	assign fOtBuckB = tmFlags[`STFSB_TM_OT_BUCKB];
	assign fOtBuckA = tmFlags[`STFSB_TM_OT_BUCKA];

	// Over-voltage view, reserved bits low
	always @* begin
		ovView    = 8'h00;
		ovView[7] = fIntReg;
		ovView[6] = 1'b0;
		ovView[5] = fExtMon2;
		ovView[4] = fExtMon1;
		ovView[3] = fOvBoost;
		ovView[2] = 1'b0;
		ovView[1] = fOvBuckB;
		ovView[0] = fOvBuckA;
	end

	// Protection view, reserved bits low
	always @* begin
		prView    = 8'h00;
		prView[7] = fClBoost;
		prView[6] = 1'b0;
		prView[5] = fClBuckB;
		prView[4] = fClBuckA;
		prView[3] = fOpBoost;
		prView[2] = 1'b0;
		prView[1] = fOpBuckB;
		prView[0] = fOpBuckA;
	end

	// Thermal and memory view, reserved bits low
	always @* begin
		tmView    = 8'h00;
		tmView[7] = 1'b0;
		tmView[6] = 1'b0;
		tmView[5] = 1'b0;
		tmView[4] = fNvm;
		tmView[3] = fOtBoost;
		tmView[2] = 1'b0;
		tmView[1] = fOtBuckB;
		tmView[0] = fOtBuckA;
	end

	// Capture value before the clearing read takes effect
	always @* begin
		case (rdSel)
			`STFSB_SEL_OVERVOLT: begin
				rdData_nxt = ovView;
			end
			`STFSB_SEL_PROTECT: begin
				rdData_nxt = prView;
			end
			`STFSB_SEL_THERMMEM: begin
				rdData_nxt = tmView;
			end
			default: begin
				rdData_nxt = 8'h00;
			end
		endcase
	end

	// Read data, held between reads
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdData_r <= `STFSB_RESET_VAL;
		end else if (rdStrobe) begin
			rdData_r <= rdData_nxt;
		end
	end

	// Answer strobe one cycle after each read
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdValid_r <= 1'b0;
		end else begin
			rdValid_r <= rdStrobe;
		end
	end

	// Error strobe for writes and unmapped reads
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdError_r <= 1'b0;
		end else begin
			rdError_r <= rdUnmapped || wrAttempt;
		end
	end

	// Outputs
	assign rdData  = rdData_r;
	assign rdValid = rdValid_r;
	assign rdError = rdError_r;

endmodule
`default_nettype wire

// ---- verification/stfsb_ctrl_model.sv ----
// Controller model issuing register read and write commands
// Assumes commands launched at falling edges of ref_clk
`timescale 1ns/1ps
`default_nettype none
module stfsb_ctrl_model (
	// Clock and answer
	input  wire logic       ref_clk,
	input  wire logic [7:0] rdData,
	input  wire logic       rdValid,
	// Commands
	output logic            rdStrobe,
	output logic [1:0]      rdSel,
	output logic            wrStrobe,
	output logic [1:0]      wrSel,
	output logic [7:0]      wrData
);
	initial {rdStrobe, rdSel, wrStrobe, wrSel, wrData} = 14'h0000;
	// One read, answer taken in the valid cycle
	task rd(input logic [1:0] s, output logic [7:0] d);
		@(negedge ref_clk);
		rdStrobe = 1'b1;
		rdSel    = s;
		@(negedge ref_clk);
		rdStrobe = 1'b0;
		rdSel    = ~s;
		d        = rdValid ? rdData : 8'hxx;
	endtask
	// Write attempt, always refused
	task wr(input logic [1:0] s, input logic [7:0] v);
		@(negedge ref_clk);
		wrStrobe = 1'b1;
		wrSel    = s;
		wrData   = v;
		@(negedge ref_clk);
		wrStrobe = 1'b0;
		wrData   = ~v;
	endtask
endmodule
`default_nettype wire

// ---- verification/stfsb_bank_props.sv ----
// Checker of the bank's read answer
// Assumes binding to stfsb_bank
`timescale 1ns/1ps
`default_nettype none
module stfsb_bank_props (
	// Clock, reset, commands, answer
	input wire logic       ref_clk,
	input wire logic       rstn,
	input wire logic       rdStrobe,
	input wire logic [1:0] rdSel,
	input wire logic       wrStrobe,
	input wire logic [7:0] rdData,
	input wire logic       rdValid,
	input wire logic       rdError
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence mapRd; rdStrobe && rdSel != 2'h3; endsequence
	sequence okAns; rdValid && !rdError; endsequence
	a_read_answered: assert property (mapRd |=> okAns)
		else $error("read unanswered");
	a_valid_only: assert property (!rdStrobe |=> !rdValid)
		else $error("stray valid");
	a_write_refused: assert property (wrStrobe |=> rdError)
		else $error("write not refused");
	a_unmapped_zero: assert property (rdStrobe && rdSel == 2'h3 |=>
		rdError && rdData == 8'h00) else $error("bad unmapped read");
	a_data_holds: assert property (!rdValid |-> $stable(rdData))
		else $error("data moved");
	a_rsvd_pair: assert property (rdValid && $past(rdSel) != 2'h2 |->
		!rdData[6] && !rdData[2]) else $error("reserved set");
	a_rsvd_therm: assert property (rdValid && $past(rdSel) == 2'h2 |->
		rdData[7:5] == 3'h0 && !rdData[2]) else $error("reserved set");
	a_reset_clear: assert property ($rose(rstn) |->
		rdData == 8'h00 && !rdValid) else $error("not cleared");
endmodule
bind stfsb_bank stfsb_bank_props chk (.ref_clk(ref_clk), .rstn(rstn),
	.rdStrobe(rdStrobe), .rdSel(rdSel), .wrStrobe(wrStrobe),
	.rdData(rdData), .rdValid(rdValid), .rdError(rdError));
`default_nettype wire

// ---- verification/stfsb_bank_tb.sv ----
// Testbench of the fault status bank
// Assumes controller model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module stfsb_bank_tb;
	logic       ref_clk, rstn, rdStrobe, wrStrobe, rdValid, rdError, errExp;
	logic [1:0] rdSel, wrSel;
	logic [7:0] wrData, rdData, expd, got;
	logic [7:0] fv [3];
	logic [7:0] em [3];
	int         n_mismatch, checks, cyc, i, k;
	stfsb_ctrl_model ctl (.ref_clk(ref_clk), .rdData(rdData),
		.rdValid(rdValid), .rdStrobe(rdStrobe), .rdSel(rdSel),
		.wrStrobe(wrStrobe), .wrSel(wrSel), .wrData(wrData));
	stfsb_bank DUT (.ref_clk(ref_clk), .rstn(rstn), .rdStrobe(rdStrobe),
		.rdSel(rdSel), .wrStrobe(wrStrobe), .wrSel(wrSel), .wrData(wrData),
		.st_internal_reg_overvolt_fail(fv[0][7]),
		.st_ext_monitor2_overvolt_fail(fv[0][5]),
		.st_ext_monitor1_overvolt_fail(fv[0][4]),
		.st_boost_overvolt_fail(fv[0][3]),
		.st_buck_b_overvolt_fail(fv[0][1]),
		.st_buck_a_overvolt_fail(fv[0][0]),
		.st_boost_current_limit_fail(fv[1][7]),
		.st_buck_b_current_limit_fail(fv[1][5]),
		.st_buck_a_current_limit_fail(fv[1][4]),
		.st_boost_out_protect_fail(fv[1][3]),
		.st_buck_b_out_protect_fail(fv[1][1]),
		.st_buck_a_out_protect_fail(fv[1][0]),
		.st_nvm_checksum_monitor_fail(fv[2][4]),
		.st_boost_overtemp_fail(fv[2][3]),
		.st_buck_b_overtemp_fail(fv[2][1]),
		.st_buck_a_overtemp_fail(fv[2][0]),
		.rdData(rdData), .rdValid(rdValid), .rdError(rdError));
	// Flag state after one edge
	function automatic logic [7:0] nxt(input logic [7:0] o, f,
		input int r, input logic rd);
		logic [7:0] m;
		m = (r == 2) ? 8'h1b : 8'hbb;
		return rd ? (f & m) : (o | (f & m));
	endfunction
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			em <= '{default: 8'h00};
			expd <= 8'h00;
			errExp <= 1'b0;
		end else begin
			errExp <= wrStrobe || (rdStrobe && rdSel == 2'h3);
			for (int r = 0; r < 3; r++)
				em[r] <= nxt(em[r], fv[r], r, rdStrobe && rdSel == r);
			if (rdStrobe)
				expd <= (rdSel == 2'h3) ? 8'h00 : em[rdSel];
		end
	end
	task chk(input string n, input logic [7:0] e, g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	always @(negedge ref_clk)
		if (rstn) chk("rdError", {7'h00, errExp}, {7'h00, rdError});
	task rdc(input logic [1:0] s);
		ctl.rd(s, got);
		chk("rdData", expd, got);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			final_report;
		end
	end
	initial begin
		{n_mismatch, checks, cyc} = 0;
		rstn = 1'b0;
		fv = '{default: 8'h00};
		void'($urandom(32'h417394ae));
		repeat (16) @(negedge ref_clk);
		rstn = 1'b1;
		for (i = 0; i < 4; i++)
			rdc(i[1:0]);
		$display("reset test done");
		fv = '{default: 8'hff};
		for (i = 0; i < 3; i++) begin
			rdc(i[1:0]);
			fv[i] = 8'h00;
			rdc(i[1:0]);
			rdc(i[1:0]);
		end
		$display("persist test done");
		for (k = 0; k < 80; k++) begin
			for (i = 0; i < 3; i++)
				fv[i] = 8'($urandom & $urandom);
			if ($urandom % 3 == 0)
				ctl.wr(2'($urandom), 8'($urandom));
			rdc(2'($urandom));
		end
		$display("random test done");
		final_report;
	end
endmodule
`default_nettype wire
